// ### core/tqec_top.sv
// Purpose: transmit queue-enable configuration bank with its register port
// Assumes: host accesses are synchronous to sys_clk, one access at a time
// Notes:   every access is answered by a one-cycle ack, one cycle after it is taken
`timescale 1ns/10ps

// Summary of operation
// - Bits 15..0 of the upper master register enable egress queues 63..48.
// - Bits 15..0 of the high master register enable egress queues 47..32.
// - Bits 15..0 of the mid master register enable egress queues 31..16.
// - Bits 15..0 of the low master register enable egress queues 15..0.
// - While the device select bit is 0 the upper two master registers have no effect.
// - A queue is enabled for shared operation when its master bit is 1, else not.
// - Sharing covers at most 32 queues, so only queues 0 to 31 take part in it.
// - Bit i of the slave register tells the master that slave queue 16+i is enabled.
// - Slave bits are written only in the master and act only in shared mode.
module tqec_top (
  input  wire logic                                          sys_clk,
  input  wire logic                                          nrst,
  input  wire logic [tqec_pkg::ADDR_W-1:0]                   reg_addr,
  input  wire logic [tqec_pkg::DATA_W-1:0]                   reg_wdata,
  input  wire logic                                          reg_wr,
  input  wire logic                                          reg_rd,
  output logic [tqec_pkg::DATA_W-1:0]                        reg_rdata,
  output logic                                               reg_ack,
  output logic                                               reg_err,
  input  wire logic                                          device_select_bit,
  input  wire logic                                          shared_mode,
  output logic [tqec_pkg::NUM_QUEUES-1:0]                    queue_en,
  output logic [tqec_pkg::SHARED_QUEUES-1:0]                 shared_queue_en,
  output logic [tqec_pkg::SHARED_QUEUES-1:tqec_pkg::SQ_BASE] slave_queue_en
);
  import tqec_pkg::*;

  tqec_state_t       state_q;
  tqec_state_t       state_d;
  tqec_idx_t         acc_idx;
  logic              acc_take;
  logic              wr_take;
  logic              rd_take;
  logic [DATA_W-1:0] rdata_d;
  logic [DATA_W-1:0] rdata_q;
  logic              err_q;

  tqec_cfg_if cfg ();

  // one decode serves both directions
  assign acc_idx  = tqec_reg_index(reg_addr);

  // requests are only taken while idle; the ack cycle refuses them
  assign acc_take = (state_q == TQEC_ST_IDLE) && (reg_wr || reg_rd);
  assign wr_take  = (state_q == TQEC_ST_IDLE) && reg_wr;
  assign rd_take  = (state_q == TQEC_ST_IDLE) && reg_rd && !reg_wr;

  always_comb begin
    state_d = state_q;
    case (state_q)
      TQEC_ST_IDLE: begin
        if (acc_take) begin
          state_d = TQEC_ST_ACK;
        end
      end
      TQEC_ST_ACK: begin
        state_d = TQEC_ST_IDLE;
      end
      default: begin
        state_d = TQEC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= TQEC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // unmapped reads return zero rather than stale data
  always_comb begin
    rdata_d = '0;
    if (acc_idx != IDX_NONE) begin
      rdata_d = cfg.regs[acc_idx];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= '0;
    end else if (rd_take) begin
      rdata_q <= rdata_d;
    end else if (wr_take) begin
      rdata_q <= '0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      err_q <= 1'b0;
    end else if (acc_take) begin
      err_q <= (acc_idx == IDX_NONE);
    end else begin
      err_q <= 1'b0;
    end
  end

  assign reg_ack   = (state_q == TQEC_ST_ACK);
  assign reg_err   = err_q;
  assign reg_rdata = rdata_q;

  tqec_regfile u_regfile (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .wr_idx  (acc_idx),
    .wr_en   (wr_take && (acc_idx != IDX_NONE)),
    .wr_data (reg_wdata),
    .cfg     (cfg.owner)
  );

  tqec_qmap u_qmap (
    .sys_clk           (sys_clk),
    .nrst              (nrst),
    .cfg               (cfg.reader),
    .device_select_bit (device_select_bit),
    .shared_mode       (shared_mode),
    .queue_en          (queue_en),
    .shared_queue_en   (shared_queue_en),
    .slave_queue_en    (slave_queue_en)
  );

  // checks: a write taken at cycle t shows on the queue vectors at t+2

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  a_upper_map: assert property (
    (wr_take && acc_idx == IDX_MQ_UPPER) ##1 device_select_bit
    |=> queue_en[63:48] == $past(reg_wdata, 2)
  ) else $error("upper master word not seen on queues 63 to 48");

  a_high_map: assert property (
    (wr_take && acc_idx == IDX_MQ_HIGH) ##1 device_select_bit
    |=> queue_en[47:32] == $past(reg_wdata, 2)
  ) else $error("high master word not seen on queues 47 to 32");

  a_mid_map: assert property (
    wr_take && acc_idx == IDX_MQ_MID
    |-> ##2 queue_en[31:16] == $past(reg_wdata, 2)
  ) else $error("mid master word not seen on queues 31 to 16");

  a_low_map: assert property (
    wr_take && acc_idx == IDX_MQ_LOW
    |-> ##2 queue_en[15:0] == $past(reg_wdata, 2)
  ) else $error("low master word not seen on queues 15 to 0");

  a_upper_gated: assert property (
    !device_select_bit |=> queue_en[NUM_QUEUES-1:GATED_BASE] == '0
  ) else $error("upper queues enabled while device select is low");

  a_shared_follow: assert property (
    shared_mode |=> shared_queue_en
      == {$past(cfg.regs[IDX_MQ_MID]), $past(cfg.regs[IDX_MQ_LOW])}
  ) else $error("shared enables differ from master bits of queues 0 to 31");

  a_shared_off: assert property (
    !shared_mode [*2] |-> shared_queue_en == '0 && slave_queue_en == '0
  ) else $error("sharing active outside shared mode");

  a_slave_map: assert property (
    (wr_take && acc_idx == IDX_SQ_UPPER) ##1 shared_mode
    |=> slave_queue_en == $past(reg_wdata, 2)
  ) else $error("slave word not seen on slave queues 31 to 16");

  a_slave_gated: assert property (
    $fell(shared_mode) |=> slave_queue_en == '0
  ) else $error("slave enables survive leaving shared mode");

  a_read_back: assert property (
    rd_take && acc_idx != IDX_NONE
    |=> reg_ack && reg_rdata == $past(cfg.regs[acc_idx])
  ) else $error("read does not return the stored word");

  a_write_read: assert property (
    (wr_take && acc_idx == IDX_MQ_MID) ##2 !reg_wr ##1
    (rd_take && acc_idx == IDX_MQ_MID)
    |=> reg_rdata == $past(reg_wdata, 4)
  ) else $error("read after write lost the written word");

  a_ack_single: assert property (
    reg_ack |=> !reg_ack
  ) else $error("ack held longer than one cycle");

  // handshake, error flag and read data

  a_ack_delay: assert property (
    acc_take |=> reg_ack
  ) else $error("access not answered one cycle after it was taken");

  a_ack_cause: assert property (
    reg_ack |-> $past(acc_take)
  ) else $error("ack without a taken access");

  a_ack_refused: assert property (
    reg_ack && (reg_wr || reg_rd) |=> !reg_ack && !reg_err
  ) else $error("request in the ack cycle was not refused");

  a_err_with_ack: assert property (
    reg_err |-> reg_ack
  ) else $error("error flag without ack");

  a_err_single: assert property (
    reg_err |=> !reg_err
  ) else $error("error flag held longer than one cycle");

  a_err_unmapped: assert property (
    acc_take && acc_idx == IDX_NONE
    |=> reg_err
  ) else $error("unmapped access not flagged");

  a_err_mapped: assert property (
    acc_take && acc_idx != IDX_NONE
    |=> !reg_err
  ) else $error("mapped access flagged as unmapped");

  a_rdata_hold: assert property (
    !acc_take |=> $stable(reg_rdata)
  ) else $error("read data changed without a taken access");

  a_rdata_write: assert property (
    wr_take
    |=> reg_rdata == '0
  ) else $error("read data not cleared by a write");

  a_rdata_unmapped: assert property (
    rd_take && acc_idx == IDX_NONE
    |=> reg_rdata == '0
  ) else $error("unmapped read returned nonzero data");

  a_write_wins: assert property (
    state_q == TQEC_ST_IDLE && reg_wr && reg_rd && acc_idx != IDX_NONE
    |=> reg_rdata == '0 && cfg.regs[$past(acc_idx)] == $past(reg_wdata)
  ) else $error("read raised with a write displaced the write");

  // storage, queue vectors and outputs after reset

  a_write_store: assert property (
    wr_take && acc_idx != IDX_NONE
    |=> cfg.regs[$past(acc_idx)] == $past(reg_wdata)
  ) else $error("written word not stored");

  a_bank_hold: assert property (
    !(wr_take && acc_idx != IDX_NONE) |=> $stable(cfg.regs)
  ) else $error("stored words changed without a mapped write");

  a_unmapped_keep: assert property (
    acc_take && acc_idx == IDX_NONE
    |=> $stable(cfg.regs)
  ) else $error("unmapped access changed the bank");

  a_gated_store: assert property (
    !device_select_bit && wr_take && acc_idx == IDX_MQ_UPPER
    |=> cfg.regs[IDX_MQ_UPPER] == $past(reg_wdata) && queue_en[NUM_QUEUES-1:GATED_BASE] == '0
  ) else $error("gated upper word not stored or not blanked");

  a_upper_pass: assert property (
    device_select_bit |=> queue_en[NUM_QUEUES-1:GATED_BASE]
      == {$past(cfg.regs[IDX_MQ_UPPER]), $past(cfg.regs[IDX_MQ_HIGH])}
  ) else $error("upper queues differ from the upper master words");

  a_lower_pass: assert property (
    1'b1 |=> queue_en[GATED_BASE-1:0]
      == {$past(cfg.regs[IDX_MQ_MID]), $past(cfg.regs[IDX_MQ_LOW])}
  ) else $error("lower queues differ from the lower master words");

  a_gate_lower: assert property (
    !device_select_bit |=> queue_en[GATED_BASE-1:0]
      == {$past(cfg.regs[IDX_MQ_MID]), $past(cfg.regs[IDX_MQ_LOW])}
  ) else $error("device select low disturbed the lower queues");

  a_shared_copy: assert property (
    shared_mode |=> shared_queue_en == queue_en[SHARED_QUEUES-1:0]
  ) else $error("shared enables differ from queues 0 to 31");

  a_slave_pass: assert property (
    shared_mode |=> slave_queue_en == $past(cfg.regs[IDX_SQ_UPPER])
  ) else $error("slave enables differ from the slave word");

  a_off_now: assert property (
    !shared_mode |=> slave_queue_en == '0 && shared_queue_en == '0
  ) else $error("shared vectors active one cycle after leaving shared mode");

  a_reset_quiet: assert property (
    $rose(nrst)
    |-> queue_en == '0 && shared_queue_en == '0 && slave_queue_en == '0
  ) else $error("queue vectors not clear after reset");

  a_reset_bus: assert property (
    $rose(nrst) |-> !reg_ack && !reg_err && reg_rdata == '0
  ) else $error("register port outputs not clear after reset");

endmodule : tqec_top

// ### pkg/tqec_pkg.sv
// Purpose: shared constants and types of the transmit queue-enable register bank
// Assumes: 16-bit registers at even byte offsets on the device's own register port
// Notes:   queue base of each master register is held here, next to its register index
package tqec_pkg;

  localparam int ADDR_W        = 10;
  localparam int DATA_W        = 16;
  localparam int NUM_REGS      = 5;
  localparam int MQ_REGS       = 4;
  localparam int NUM_QUEUES    = 64;
  localparam int SHARED_QUEUES = 32;
  localparam int GATED_BASE    = 32;
  localparam int SQ_BASE       = 16;

  typedef logic [2:0] tqec_idx_t;

  localparam tqec_idx_t IDX_MQ_UPPER = 3'h0;
  localparam tqec_idx_t IDX_MQ_HIGH  = 3'h1;
  localparam tqec_idx_t IDX_MQ_MID   = 3'h2;
  localparam tqec_idx_t IDX_MQ_LOW   = 3'h3;
  localparam tqec_idx_t IDX_SQ_UPPER = 3'h4;
  localparam tqec_idx_t IDX_NONE     = 3'h7;

  localparam logic [ADDR_W-1:0] OFS_MQ_UPPER = 10'h158;
  localparam logic [ADDR_W-1:0] OFS_MQ_HIGH  = 10'h15a;
  localparam logic [ADDR_W-1:0] OFS_MQ_MID   = 10'h15c;
  localparam logic [ADDR_W-1:0] OFS_MQ_LOW   = 10'h15e;
  localparam logic [ADDR_W-1:0] OFS_SQ_UPPER = 10'h16c;

  localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;

  // first egress queue served by each master register, by register index
  localparam int        MQ_BASE [MQ_REGS] = '{48, 32, 16, 0};
  localparam tqec_idx_t MQ_IDX  [MQ_REGS] = '{IDX_MQ_UPPER, IDX_MQ_HIGH, IDX_MQ_MID, IDX_MQ_LOW};

  typedef enum logic [1:0] {
    TQEC_ST_IDLE = 2'b01,
    TQEC_ST_ACK  = 2'b10
  } tqec_state_t;

  function automatic tqec_idx_t tqec_reg_index(input logic [ADDR_W-1:0] addr);
    case (addr)
      OFS_MQ_UPPER: tqec_reg_index = IDX_MQ_UPPER;
      OFS_MQ_HIGH:  tqec_reg_index = IDX_MQ_HIGH;
      OFS_MQ_MID:   tqec_reg_index = IDX_MQ_MID;
      OFS_MQ_LOW:   tqec_reg_index = IDX_MQ_LOW;
      OFS_SQ_UPPER: tqec_reg_index = IDX_SQ_UPPER;
      default:      tqec_reg_index = IDX_NONE;
    endcase
  endfunction : tqec_reg_index

endpackage : tqec_pkg

// ### pkg/tqec_cfg_if.sv
// Purpose: carries the stored register words from the register file to its readers
// Assumes: one writer, any number of readers
// Notes:   no clocking, plain wires
`timescale 1ns/10ps
interface tqec_cfg_if;
  import tqec_pkg::*;
  logic [NUM_REGS-1:0][DATA_W-1:0] regs;
  modport owner  (output regs);
  modport reader (input regs);
endinterface : tqec_cfg_if

// ### core/tqec_regfile.sv
// Purpose: storage of the queue-enable register words
// Assumes: at most one write per cycle, index already decoded
// Notes:   every word clears to zero and holds until written
`timescale 1ns/10ps
module tqec_regfile (
  input  wire logic                        sys_clk,
  input  wire logic                        nrst,
  input  wire tqec_pkg::tqec_idx_t         wr_idx,
  input  wire logic                        wr_en,
  input  wire logic [tqec_pkg::DATA_W-1:0] wr_data,
  tqec_cfg_if.owner                        cfg
);
  import tqec_pkg::*;

  for (genvar g = 0; g < NUM_REGS; g++) begin : g_word
    logic [DATA_W-1:0] word_q;

    always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
        word_q <= REG_RESET;
      end else if (wr_en && (wr_idx == tqec_idx_t'(g))) begin
        word_q <= wr_data;
      end
    end

    assign cfg.regs[g] = word_q;
  end

endmodule : tqec_regfile

// ### core/tqec_qmap.sv
// Purpose: turns stored words into per-queue enable vectors
// Assumes: select and shared-mode levels come from the main configuration logic
// Notes:   outputs are registered, so they follow the words by one cycle
`timescale 1ns/10ps
module tqec_qmap (
  input  wire logic                                                     sys_clk,
  input  wire logic                                                     nrst,
  tqec_cfg_if.reader                                                    cfg,
  input  wire logic                                                     device_select_bit,
  input  wire logic                                                     shared_mode,
  output logic [tqec_pkg::NUM_QUEUES-1:0]                               queue_en,
  output logic [tqec_pkg::SHARED_QUEUES-1:0]                            shared_queue_en,
  output logic [tqec_pkg::SHARED_QUEUES-1:tqec_pkg::SQ_BASE]            slave_queue_en
);
  import tqec_pkg::*;

  logic [NUM_QUEUES-1:0]            queue_en_d;
  logic [SHARED_QUEUES-1:0]         shared_en_d;
  logic [SHARED_QUEUES-1:SQ_BASE]   slave_en_d;

  for (genvar g = 0; g < MQ_REGS; g++) begin : g_map
    // upper half is meaningless unless the second device is selected
    if (MQ_BASE[g] >= GATED_BASE) begin : g_gated
      assign queue_en_d[MQ_BASE[g] +: DATA_W] =
        device_select_bit ? cfg.regs[MQ_IDX[g]] : '0;
    end else begin : g_plain
      assign queue_en_d[MQ_BASE[g] +: DATA_W] = cfg.regs[MQ_IDX[g]];
    end
  end

  // only the lower 32 queues take part in sharing
  assign shared_en_d = shared_mode ? queue_en_d[SHARED_QUEUES-1:0] : '0;
  assign slave_en_d  = shared_mode ? cfg.regs[IDX_SQ_UPPER] : '0;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      queue_en        <= '0;
      shared_queue_en <= '0;
      slave_queue_en  <= '0;
    end else begin
      queue_en        <= queue_en_d;
      shared_queue_en <= shared_en_d;
      slave_queue_en  <= slave_en_d;
    end
  end

endmodule : tqec_qmap

// ### test/tqec_top_tb.sv
// Purpose: self-checking bench for the transmit queue-enable register bank
// Assumes: one-cycle ack handshake, queue outputs one cycle behind the stored words
// Notes:   inputs change on the falling edge; assertions live in the design files
`timescale 1ns/10ps
module tqec_top_tb;
  import tqec_pkg::*;

  typedef struct {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    int                base;
  } tqec_row_t;

  logic                                  sys_clk;
  logic                                  nrst;
  logic [ADDR_W-1:0]                     reg_addr;
  logic [DATA_W-1:0]                     reg_wdata;
  logic                                  reg_wr;
  logic                                  reg_rd;
  logic [DATA_W-1:0]                     reg_rdata;
  logic                                  reg_ack;
  logic                                  reg_err;
  logic                                  device_select_bit;
  logic                                  shared_mode;
  logic [NUM_QUEUES-1:0]                 queue_en;
  logic [SHARED_QUEUES-1:0]              shared_queue_en;
  logic [SHARED_QUEUES-1:SQ_BASE]        slave_queue_en;
  logic [DATA_W-1:0]                     got;
  logic                                  got_err;
  int                                    failures;
  int                                    n_checks;

  // bit 0 and a distinct high bit (15, 14, 13, 12) set so a reversed or shifted slice shows
  tqec_row_t rows [4] = '{'{OFS_MQ_UPPER, 16'h8001, 48}, '{OFS_MQ_HIGH, 16'h4003, 32},
                          '{OFS_MQ_MID, 16'h2005, 16}, '{OFS_MQ_LOW, 16'h100f, 0}};

  tqec_top i_tqec_top (
    .sys_clk           (sys_clk),
    .nrst              (nrst),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .reg_ack           (reg_ack),
    .reg_err           (reg_err),
    .device_select_bit (device_select_bit),
    .shared_mode       (shared_mode),
    .queue_en          (queue_en),
    .shared_queue_en   (shared_queue_en),
    .slave_queue_en    (slave_queue_en)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic fail(input string msg);
    failures++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask : fail

  // counts the comparison and reports a four-state difference
  function automatic bit cmp(input logic [63:0] a, input logic [63:0] b);
    n_checks++;
    return a !== b;
  endfunction : cmp

  // called at a falling edge; request stands across the edge that samples ack
  task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int i;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = wr;
    reg_rd    = !wr;
    for (i = 0; i < 8 && reg_ack !== 1'b1; i++) @(negedge sys_clk);
    if (reg_ack !== 1'b1) begin
      fail("no ack");
      end_of_test();
    end
    if (cmp(i, 1)) fail("ack latency");
    got     = reg_rdata;
    got_err = reg_err;
    @(negedge sys_clk);
    reg_wr  = 1'b0;
    reg_rd  = 1'b0;
    @(negedge sys_clk);
  endtask : access

  initial begin
    failures = 0;
    n_checks = 0;
    nrst = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    device_select_bit = 1'b0;
    shared_mode = 1'b0;
    repeat (6) @(negedge sys_clk);
    nrst = 1'b1;
    @(negedge sys_clk);
    foreach (rows[k]) begin
      access(1'b0, rows[k].addr, 16'h0);
      if (cmp(got, 0)) fail("reset value");
    end
    access(1'b0, OFS_SQ_UPPER, 16'h0);
    if (cmp(got, 0)) fail("slave reset value");
    if (cmp(queue_en, 0)) fail("queues after reset");
    device_select_bit = 1'b1;
    shared_mode = 1'b1;
    foreach (rows[k]) access(1'b1, rows[k].addr, rows[k].data);
    @(negedge sys_clk);
    foreach (rows[k]) begin
      if (cmp(queue_en[rows[k].base +: 16], rows[k].data)) fail("queue map");
      access(1'b0, rows[k].addr, 16'h0);
      if (cmp({got_err, got}, {1'b0, rows[k].data})) fail("read back");
    end
    if (cmp(shared_queue_en, {rows[2].data, rows[3].data})) fail("shared set");
    // select low: upper half blanked, words still stored
    device_select_bit = 1'b0;
    repeat (2) @(negedge sys_clk);
    if (cmp(queue_en, {32'h0, rows[2].data, rows[3].data})) fail("select gate");
    access(1'b0, OFS_MQ_UPPER, 16'h0);
    if (cmp(got, rows[0].data)) fail("gated word read");
    access(1'b1, OFS_MQ_UPPER, 16'h0ff0);
    if (cmp(queue_en[63:32], 0)) fail("gated write shows");
    device_select_bit = 1'b1;
    access(1'b1, OFS_SQ_UPPER, 16'h8001);
    @(negedge sys_clk);
    if (cmp(slave_queue_en, 16'h8001)) fail("slave map");
    if (cmp(queue_en[63:32], {16'h0ff0, rows[1].data})) fail("stored while gated");
    shared_mode = 1'b0;
    repeat (2) @(negedge sys_clk);
    if (cmp(slave_queue_en, 0)) fail("slave outside shared");
    if (cmp(shared_queue_en, 0)) fail("shared outside shared");
    if (cmp(queue_en[31:0], {rows[2].data, rows[3].data})) fail("non-shared queues");
    access(1'b0, OFS_SQ_UPPER, 16'h0);
    if (cmp(got, 16'h8001)) fail("slave read back");
    // unmapped accesses are acked with the error flag and leave the bank alone
    access(1'b1, 10'h160, 16'hffff);
    if (cmp(got_err, 1)) fail("unmapped write err");
    access(1'b0, 10'h160, 16'h0);
    if (cmp({got_err, got}, {1'b1, 16'h0})) fail("unmapped read");
    access(1'b0, OFS_MQ_LOW, 16'h0);
    if (cmp(got, rows[3].data)) fail("word after unmapped");
    // write and read raised together: the write wins
    reg_addr  = OFS_MQ_LOW;
    reg_wdata = 16'h3c3c;
    reg_wr    = 1'b1;
    reg_rd    = 1'b1;
    @(negedge sys_clk);
    if (cmp({reg_ack, reg_rdata}, {1'b1, 16'h0})) fail("write with read");
    @(negedge sys_clk);
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    @(negedge sys_clk);
    access(1'b0, OFS_MQ_LOW, 16'h0);
    if (cmp(got, 16'h3c3c)) fail("write won over read");
    // read straight after a write to the same word
    access(1'b1, OFS_MQ_MID, 16'ha55a);
    access(1'b0, OFS_MQ_MID, 16'h0);
    if (cmp(got, 16'ha55a)) fail("read after write");
    // second reset in mid-run
    nrst = 1'b0;
    @(negedge sys_clk);
    if (cmp(queue_en, 0)) fail("queues in reset");
    if (cmp({reg_ack, reg_err, reg_rdata}, 0)) fail("bus outputs in reset");
    nrst = 1'b1;
    @(negedge sys_clk);
    access(1'b0, OFS_MQ_UPPER, 16'h0);
    if (cmp(got, 0)) fail("cleared by reset");
    end_of_test();
  end

endmodule : tqec_top_tb
